/* logic/ioa_input_stream_offset_alignment.sv */
// Per-stream input frame offset alignment with APB register access
`timescale 1ns/10ps

// Function
// - Each of sixteen streams has its own 3-bit offset and latch-edge bit.
// - Offset sets delay from frame pulse until bit 0 is captured.
// - Input offset reaches at most 4.5 clock periods after frame pulse; the registers accept offset 7 with latch bit set, up to 7.5 periods.
// - Standard mode: cleared bit samples rising edge, set bit falling edge.
// - GCI mode: cleared bit samples falling edge, set bit rising edge.
// - Shift equals offset periods plus half period when latch bit set.
// - Zero offset and zero latch bit apply no shift; default setting.
// - Measured delay low bits give offset; half flag low sets latch bit.
// - All offset registers clear to zero on reset.
module ioa_input_stream_offset_alignment #(
  parameter int HALF_DIV = 4,
  parameter int CNT_W    = 16
)(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ioa_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     frame_pulse_in_n,
  input  wire logic [15:0]              rx_in,
  output logic      [15:0]              rx_data,
  output logic      [15:0]              rx_strobe,
  output logic      [15:0]              rx_bit0,
  output logic      [15:0]              sample_falling
);
  localparam int NS = ioa_pkg::NUM_STREAMS;
  localparam int NW = ioa_pkg::NIBBLE_W;
  localparam int RW = ioa_pkg::REG_W;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_DIV - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [ioa_pkg::CFG_W-1:0] cfg_q;
  logic [ioa_pkg::CFG_W-1:0] cfg_d;
  logic                      gci_q;
  logic                      fp_s1_q;
  logic                      fp_s2_q;
  logic                      fp_s3_q;
  logic [NS-1:0]             rx_s1_q;
  logic [NS-1:0]             rx_s2_q;
  logic [CNT_W-1:0]          div_q;
  logic [CNT_W-1:0]          half_q;
  logic                      run_q;
  logic                      step_q;
  logic                      no_wr_q;

  // Bus decode
  wire [ioa_pkg::IDX_W-1:0] idx = paddr[ioa_pkg::ADDR_W-1:2];
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready;
  wire hit_off = (idx >= ioa_pkg::IDX_OFF0) && (idx <= ioa_pkg::IDX_OFF3);
  wire hit_ctl = idx == ioa_pkg::IDX_CTRL;
  wire hit_imp = idx == ioa_pkg::IDX_IMPORT;
  wire mapped  = hit_off | hit_ctl | hit_imp;
  wire wr      = access & pwrite;
  wire wr_off  = wr & hit_off;
  wire wr_ctl  = wr & hit_ctl;
  wire wr_imp  = wr & hit_imp;
  wire [1:0] reg_sel = 2'(idx - ioa_pkg::IDX_OFF0);
  wire [3:0] imp_stream = pwdata[ioa_pkg::IMP_STREAM_LSB +: 4];
  wire [NW-1:0] imp_nib = ioa_pkg::to_nibble(
    pwdata[ioa_pkg::IMP_DELAY_LSB +: ioa_pkg::OFFSET_W],
    pwdata[ioa_pkg::IMP_HALF_BIT]);
  wire [RW-1:0] off_word = cfg_q[{reg_sel, 4'h0} +: RW];
  wire [31:0] rd_word =
    hit_off ? {16'h0000, off_word} :
    hit_ctl ? {31'h00000000, gci_q} : 32'h00000000;

  // Config write and measurement import
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_off)
      cfg_d[{reg_sel, 4'h0} +: RW] = pwdata[RW-1:0];
    if (wr_imp)
      cfg_d[{imp_stream, 2'h0} +: NW] = imp_nib;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= {ioa_pkg::NUM_OFF_REGS{ioa_pkg::OFF_RESET}};
      gci_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      if (wr_ctl)
        gci_q <= pwdata[ioa_pkg::CTRL_GCI_BIT];
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= rd_word;
    end
  end

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp_s1_q <= 1'b1;
      fp_s2_q <= 1'b1;
      fp_s3_q <= 1'b1;
      rx_s1_q <= 16'h0000;
      rx_s2_q <= 16'h0000;
    end
    else
    begin
      fp_s1_q <= frame_pulse_in_n;
      fp_s2_q <= fp_s1_q;
      fp_s3_q <= fp_s2_q;
      rx_s1_q <= rx_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Half period timebase restarted by the frame pulse
  wire fp_edge   = fp_s3_q & ~fp_s2_q;
  wire half_tick = div_q == HALF_LAST;
  wire advance   = half_tick & run_q & (half_q != CNT_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= '0;
      half_q <= '0;
      run_q  <= 1'b0;
      step_q <= 1'b0;
    end
    else
    begin
      div_q  <= (fp_edge | half_tick) ? '0 : div_q + 1'b1;
      run_q  <= run_q | fp_edge;
      step_q <= fp_edge | advance;
      if (fp_edge)
        half_q <= '0;
      else if (advance)
        half_q <= half_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      no_wr_q <= 1'b1;
    else if (wr_off | wr_imp)
      no_wr_q <= 1'b0;
  end

  // Per-stream capture
  for (genvar s = 0; s < NS; s++)
  begin : g_stream
    wire [NW-1:0] nib = cfg_q[s*NW +: NW];
    wire [3:0] sh = ioa_pkg::shift_halves(nib);
    wire [CNT_W-1:0] sh_w = CNT_W'(sh);
    wire at_bit0 = half_q == sh_w;
    wire on_cell = (half_q >= sh_w) && (half_q[0] == sh[0]);
    wire edge_f  = nib[ioa_pkg::DLE_POS] ^ gci_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rx_data[s]        <= 1'b0;
        rx_strobe[s]      <= 1'b0;
        rx_bit0[s]        <= 1'b0;
        sample_falling[s] <= 1'b0;
      end
      else
      begin
        rx_strobe[s]      <= step_q & on_cell;
        rx_bit0[s]        <= step_q & at_bit0;
        sample_falling[s] <= edge_f;
        if (step_q & on_cell)
          rx_data[s] <= rx_s2_q[s];
      end
    end

    sequence frame_begin;
      fp_edge ##1 (step_q && half_q == '0);
    endsequence

    zero_shift_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      frame_begin ##0 (nib == '0) |=> rx_bit0[s])
      else $error("zero setting did not capture bit 0 at once");

    shift_limit_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      sh <= ioa_pkg::MAX_SHIFT_HALVES)
      else $error("shift above 4.5 periods");

    bit0_time_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_bit0[s] |-> $past(half_q) == CNT_W'(2 * nib[3:1] + nib[0]))
      else $error("bit 0 captured at wrong half period");

    edge_std_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!gci_q && !nib[0])[*2] |-> !sample_falling[s])
      else $error("standard mode cleared bit not rising edge");

    edge_gci_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (gci_q && !nib[0])[*2] |-> sample_falling[s])
      else $error("gci mode cleared bit not falling edge");

    strobe_gap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_strobe[s] |=> !rx_strobe[s])
      else $error("strobes closer than one half period");

    edge_std_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!gci_q && nib[0])[*2] |-> sample_falling[s])
      else $error("standard mode set bit not falling edge");

    edge_gci_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (gci_q && nib[0])[*2] |-> !sample_falling[s])
      else $error("gci mode set bit not rising edge");

    bit0_strobe_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_bit0[s] |-> rx_strobe[s])
      else $error("bit 0 marked without a capture strobe");

    capture_data_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_strobe[s] |-> rx_data[s] == $past(rx_s2_q[s]))
      else $error("captured bit differs from synchronised pin");
  end

  reset_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    no_wr_q |-> cfg_q == '0)
    else $error("offsets not zero after reset");

  reg_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_off && idx == ioa_pkg::IDX_OFF3 |=>
      cfg_q[ioa_pkg::CFG_W-1 -: RW] == $past(pwdata[RW-1:0]))
    else $error("offset register write lost");

  import_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_imp && pwdata[7:4] == 4'h0 |=>
      cfg_q[NW-1:0] == {$past(pwdata[2:0]), !$past(pwdata[3])})
    else $error("measured delay not mapped to offset");

  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("apb answer timing broken");

  apb_error_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr && pready)
    else $error("unmapped access not flagged");

  ready_cause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup))
    else $error("ready without a setup cycle");

  read_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite |=> prdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");

  early_strobe_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !run_q |=> rx_strobe == '0)
    else $error("strobe before the first frame pulse");

  mode_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctl |=> gci_q == $past(pwdata[ioa_pkg::CTRL_GCI_BIT]))
    else $error("mode bit write lost");
endmodule

/* logic/ioa_pkg.sv */
// Constants for the per-stream input offset alignment block
package ioa_pkg;
  localparam int NUM_STREAMS = 16;
  localparam int NIBBLE_W = 4;
  localparam int OFFSET_W = 3;
  localparam int REG_W = 16;
  localparam int NUM_OFF_REGS = 4;
  localparam int CFG_W = NUM_STREAMS * NIBBLE_W;
  localparam int ADDR_W = 8;
  localparam int IDX_W = ADDR_W - 2;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OFF0 = 6'h03;
  localparam logic [IDX_W-1:0] IDX_OFF3 = 6'h06;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h07;
  localparam logic [IDX_W-1:0] IDX_IMPORT = 6'h08;
  // Nibble layout
  localparam int DLE_POS = 0;
  localparam int OFF_LSB = 1;
  // Control register
  localparam int CTRL_GCI_BIT = 0;
  // Import register layout
  localparam int IMP_DELAY_LSB = 0;
  localparam int IMP_HALF_BIT = 3;
  localparam int IMP_STREAM_LSB = 4;
  localparam logic [REG_W-1:0] OFF_RESET = 16'h0000;
  localparam logic [3:0] MAX_SHIFT_HALVES = 4'h9;

  // Measured delay to offset nibble
  function automatic logic [NIBBLE_W-1:0] to_nibble(
    input logic [OFFSET_W-1:0] measured_delay_low,
    input logic                half_period_flag);
    to_nibble = {measured_delay_low, ~half_period_flag};
  endfunction

  // Shift in half clock periods: offset whole periods plus one half when latch bit set
  function automatic logic [3:0] shift_halves(
    input logic [NIBBLE_W-1:0] nib);
    shift_halves = {nib[NIBBLE_W-1:OFF_LSB], 1'b0} + {3'h0, nib[DLE_POS]};
  endfunction
endpackage

/* test/ioa_frame_source.sv */
// Frame pulse and receive stream source standing in for the backplane
`timescale 1ns/10ps
module ioa_frame_source #(
  parameter int PULSE_LEN = 4
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  output logic             frame_pulse_in_n,
  output logic [15:0]      rx_in
);
  logic [7:0] len_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      len_q            <= 8'h00;
      frame_pulse_in_n <= 1'b1;
      rx_in            <= 16'h0000;
    end
    else
    begin
      // Lines under set bits of 16'hA5C3 toggle every cycle; the other lines stay low
      rx_in            <= rx_in ^ 16'hA5C3;
      len_q            <= go ? 8'(PULSE_LEN) : len_q - 8'(len_q != 0);
      frame_pulse_in_n <= !(go || len_q > 8'h01);
    end
endmodule

/* test/input_stream_offset_alignment_test.sv */
// Self-checking bench for the input offset alignment block
`timescale 1ns/10ps
module input_stream_offset_alignment_test;
  localparam int HD = 2;
  localparam logic [15:0] PAT = 16'hA5C3;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        go = 0, er, pready, pslverr, fp_n;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] rx_in, rx_data, rx_strobe, rx_bit0, sample_falling;
  logic [15:0] exp_edge = 16'h0000;
  logic [15:0] stb = 16'h0000, dat_g = 16'h0000, dat_e = 16'h0000;
  logic [15:0] exp_reg [4] = '{default: 16'h0000};
  logic [7:0]  row_imp [10];
  logic [3:0]  row_nib [10];
  int          failures = 0, n_checks = 0, cyc = 0, at [16];

  ioa_input_stream_offset_alignment #(.HALF_DIV(HD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_pulse_in_n(fp_n),
    .rx_in(rx_in), .rx_data(rx_data), .rx_strobe(rx_strobe),
    .rx_bit0(rx_bit0), .sample_falling(sample_falling));
  ioa_frame_source src (.pclk(pclk), .presetn(presetn), .go(go),
    .frame_pulse_in_n(fp_n), .rx_in(rx_in));

  always #10 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    for (int s = 0; s < 16; s++)
      if (rx_bit0[s] === 1'b1 && at[s] < 0)
      begin
        at[s]    = cyc;
        stb[s]   = rx_strobe[s];
        dat_g[s] = rx_data[s];
        dat_e[s] = rx_in[s] ^ PAT[s];
      end
    if (cyc == 4000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    for (int i = 0; i < 16; i++)
      at[i] = -1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      apb(8'(12 + 4 * r), 1'b0, 32'h0, rd, er);
      chk("reset offset", 32'h0, rd);
    end
    chk("reset edge", 32'h0, {16'h0, sample_falling});
    $display("test reset done");
    // Rows: one stream per shift setting, entered as measured results
    for (int h = 0; h < 10; h++)
    begin
      row_imp[h] = {4'(h), ~h[0], 3'(h / 2)};
      row_nib[h] = {3'(h / 2), h[0]};
      exp_reg[h / 4][4 * (h % 4) +: 4] = row_nib[h];
      exp_edge[h] = h[0];
    end
    for (int h = 0; h < 10; h++)
      apb(8'h20, 1'b1, {24'h0, row_imp[h]}, rd, er);
    for (int r = 0; r < 4; r++)
    begin
      apb(8'(12 + 4 * r), 1'b0, 32'h0, rd, er);
      chk("offset reg", {16'h0, exp_reg[r]}, rd);
    end
    chk("edge std", {16'h0, exp_edge}, {16'h0, sample_falling});
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("bit0 seen", 32'h1, 32'(at[0] > 0));
    for (int s = 1; s < 16; s++)
      chk("bit0 delay", 32'(s < 10 ? s * HD : 0), 32'(at[s] - at[0]));
    chk("bit0 strobe", 32'h0000FFFF, {16'h0, stb});
    chk("bit0 data", {16'h0, dat_e}, {16'h0, dat_g});
    $display("test rows done");
    apb(8'h1C, 1'b1, 32'h1, rd, er);
    repeat (2) @(posedge pclk);
    chk("edge gci", {16'h0, ~exp_edge}, {16'h0, sample_falling});
    apb(8'h18, 1'b1, 32'hFFFF_8735, rd, er);
    apb(8'h18, 1'b0, 32'h0, rd, er);
    chk("direct write", 32'h0000_8735, rd);
    apb(8'hFC, 1'b0, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(8'h20, 1'b0, 32'h0, rd, er);
    chk("import read", 32'h0, rd);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(8'h18, 1'b0, 32'h0, rd, er);
    chk("second reset", 32'h0, rd);
    $display("test awkward done");
    summarize();
  end
endmodule
